// [hrc_map.vh]
// Register map, reset values and timing for the host run / commit block
`ifndef HRC_MAP_VH
`define HRC_MAP_VH

// Bus slave address (7 bit)
`define HRC_I2C_ADDR 7'h43

// Register offsets
`define HRC_REG_CFG_BASE 8'h0A
`define HRC_REG_CFG_LAST 8'h0D
`define HRC_REG_COMMIT 8'h19
`define HRC_REG_RUN 8'h1D

// Commit trigger
`define HRC_COMMIT_CODE 8'h46
`define HRC_COMMIT_READ 8'h00

// Persistent defaults, millivolts
`define HRC_SHDN_RST 16'h0B86
`define HRC_VOUT_RST 16'h0F28

// Number of persistent bytes and their last index
`define HRC_CFG_BYTES 4
`define HRC_CFG_LAST_IDX 2'h3

// Timing
`define HRC_CLK_KHZ 100000
`define HRC_LED_HALF_MS 250

`endif

// [hrc_core.v]
// Host run state tracking, power sequencing and configuration commit
`timescale 1ns/10ps
`default_nettype none
`include "hrc_map.vh"

module hrc_core #(
  parameter [31:0] LED_HALF_CYC = `HRC_LED_HALF_MS * `HRC_CLK_KHZ
)(
  input wire clk_i,
  input wire rst_n_i,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output reg sda_oe_o,
  input wire touch_i,
  input wire host_alive_i,
  input wire [15:0] vbat_mv_i,
  input wire [15:0] vout_mv_i,
  output reg host_pwr_o,
  output reg power_indicator_led_o,
  output reg nvm_req_o,
  output reg nvm_we_o,
  output reg [1:0] nvm_addr_o,
  output reg [7:0] nvm_wdata_o,
  input wire [7:0] nvm_rdata_i,
  input wire nvm_ack_i,
  output wire commit_busy_o
);

  localparam [1:0] P_OFF = 2'h0;
  localparam [1:0] P_BOOT = 2'h1;
  localparam [1:0] P_RUN = 2'h2;
  localparam [1:0] P_SHDN = 2'h3;

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_ADDR = 3'h1;
  localparam [2:0] I_PTR = 3'h2;
  localparam [2:0] I_WR = 3'h3;
  localparam [2:0] I_RD = 3'h4;
  localparam [2:0] I_ACK = 3'h5;
  localparam [2:0] I_MACK = 3'h6;

  localparam [1:0] N_LOAD = 2'h0;
  localparam [1:0] N_IDLE = 2'h1;
  localparam [1:0] N_STORE = 2'h2;

  localparam [15:0] SHDN_RST = `HRC_SHDN_RST;
  localparam [15:0] VOUT_RST = `HRC_VOUT_RST;

  reg [1:0] pstate;
  reg [1:0] next_pstate;
  reg [7:0] cfg [0:`HRC_CFG_BYTES-1];
  reg [1:0] nstate;
  reg [1:0] nidx;
  reg [3:0] pin_s1;
  reg [3:0] pin_s2;
  reg [3:0] pin_s3;
  reg [3:0] pin_f;
  reg [3:0] pin_d;
  reg [2:0] istate;
  reg [2:0] ack_next;
  reg ack_ph;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg wr_stb;
  reg [7:0] wr_addr;
  reg [7:0] wr_data;
  reg [31:0] led_cnt;
  reg led_phase;

  wire scl_f = pin_f[0];
  wire sda_f = pin_f[1];
  wire scl_rise = scl_f & ~pin_d[0];
  wire scl_fall = ~scl_f & pin_d[0];
  wire i2c_start = scl_f & pin_d[0] & ~sda_f & pin_d[1];
  wire i2c_stop = scl_f & pin_d[0] & sda_f & ~pin_d[1];
  wire touch_rise = pin_f[2] & ~pin_d[2];
  wire host_alive = pin_f[3];
  wire [7:0] rx_byte = {shreg[6:0], sda_f};
  wire [15:0] shdn_mv = {cfg[1], cfg[0]};
  wire [15:0] output_boot_block_level_mv = {cfg[3], cfg[2]};
  wire vbat_low = vbat_mv_i < shdn_mv;
  wire boot_block = vout_mv_i > output_boot_block_level_mv;
  wire run_wr = wr_stb & (wr_addr == `HRC_REG_RUN);
  wire commit_go = wr_stb & (wr_addr == `HRC_REG_COMMIT) &
    (wr_data == `HRC_COMMIT_CODE) & (nstate == N_IDLE);

  assign sda_o = 1'b0;
  assign commit_busy_o = (nstate != N_IDLE);

  function in_cfg;
    input [7:0] a;
    begin
      in_cfg = (a >= `HRC_REG_CFG_BASE) && (a <= `HRC_REG_CFG_LAST);
    end
  endfunction

  // Register offset to persistent byte index
  function [1:0] cfg_idx;
    input [7:0] a;
    reg [7:0] off;
    begin
      off = a - `HRC_REG_CFG_BASE;
      cfg_idx = off[1:0];
    end
  endfunction

  function [7:0] rd_data;
    input [7:0] a;
    begin
      if (in_cfg(a))
        rd_data = cfg[cfg_idx(a)];
      else if (a == `HRC_REG_RUN)
        rd_data = {7'h00, pstate == P_RUN};
      else
        rd_data = `HRC_COMMIT_READ;
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pin_s1 <= 4'h3;
      pin_s2 <= 4'h3;
      pin_s3 <= 4'h3;
      pin_f <= 4'h3;
      pin_d <= 4'h3;
    end
    else
    begin
      pin_s1 <= {host_alive_i, touch_i, sda_i, scl_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_f & (pin_s2 ^ pin_s3)) | (pin_s3 & ~(pin_s2 ^ pin_s3));
      pin_d <= pin_f;
    end
  end

  // ----------------------------------------------------------------
  // Serial register port
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      istate <= I_IDLE;
      ack_next <= I_IDLE;
      ack_ph <= 1'b0;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (i2c_start)
      begin
        istate <= I_ADDR;
        bitcnt <= 3'h0;
        sda_oe_o <= 1'b0;
      end
      else if (i2c_stop)
      begin
        istate <= I_IDLE;
        sda_oe_o <= 1'b0;
      end
      else
      begin
        case (istate)
          I_ADDR, I_PTR, I_WR:
          begin
            if (scl_rise)
            begin
              shreg <= rx_byte;
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7)
              begin
                istate <= I_ACK;
                ack_ph <= 1'b0;
                if (istate == I_ADDR)
                begin
                  if (shreg[6:0] != `HRC_I2C_ADDR)
                    istate <= I_IDLE;
                  ack_next <= sda_f ? I_RD : I_PTR;
                end
                else if (istate == I_PTR)
                begin
                  ptr <= rx_byte;
                  ack_next <= I_WR;
                end
                else
                begin
                  wr_stb <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= rx_byte;
                  ptr <= ptr + 8'h01;
                  ack_next <= I_WR;
                end
              end
            end
          end
          I_ACK:
          begin
            if (scl_fall)
            begin
              if (!ack_ph)
              begin
                ack_ph <= 1'b1;
                sda_oe_o <= 1'b1;
              end
              else
              begin
                istate <= ack_next;
                bitcnt <= 3'h0;
                if (ack_next == I_RD)
                begin
                  shreg <= rd_data(ptr);
                  sda_oe_o <= ~|(rd_data(ptr) & 8'h80);
                end
                else
                  sda_oe_o <= 1'b0;
              end
            end
          end
          I_RD:
          begin
            if (scl_fall)
              sda_oe_o <= ~shreg[7];
            else if (scl_rise)
            begin
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7)
                istate <= I_MACK;
            end
          end
          I_MACK:
          begin
            if (scl_fall)
              sda_oe_o <= 1'b0;
            else if (scl_rise)
            begin
              ptr <= ptr + 8'h01;
              bitcnt <= 3'h0;
              shreg <= rd_data(ptr + 8'h01);
              istate <= sda_f ? I_IDLE : I_RD;
            end
          end
          default:
            istate <= I_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Persistent settings and commit engine
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg[0] <= SHDN_RST[7:0];
      cfg[1] <= SHDN_RST[15:8];
      cfg[2] <= VOUT_RST[7:0];
      cfg[3] <= VOUT_RST[15:8];
      nstate <= N_LOAD;
      nidx <= 2'h0;
      nvm_req_o <= 1'b0;
      nvm_we_o <= 1'b0;
      nvm_addr_o <= 2'h0;
      nvm_wdata_o <= 8'h00;
    end
    else
    begin
      if (wr_stb && in_cfg(wr_addr))
        cfg[cfg_idx(wr_addr)] <= wr_data;
      case (nstate)
        N_LOAD:
        begin
          nvm_req_o <= 1'b1;
          nvm_we_o <= 1'b0;
          nvm_addr_o <= nidx;
          if (nvm_req_o && nvm_ack_i)
          begin
            cfg[nidx] <= nvm_rdata_i;
            nidx <= nidx + 2'h1;
            nvm_req_o <= 1'b0;
            if (nidx == `HRC_CFG_LAST_IDX)
              nstate <= N_IDLE;
          end
        end
        N_IDLE:
        begin
          nidx <= 2'h0;
          if (commit_go)
            nstate <= N_STORE;
        end
        N_STORE:
        begin
          nvm_req_o <= 1'b1;
          nvm_we_o <= 1'b1;
          nvm_addr_o <= nidx;
          nvm_wdata_o <= cfg[nidx];
          if (nvm_req_o && nvm_ack_i)
          begin
            nidx <= nidx + 2'h1;
            nvm_req_o <= 1'b0;
            if (nidx == `HRC_CFG_LAST_IDX)
              nstate <= N_IDLE;
          end
        end
        default:
          nstate <= N_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Host power state
  // ----------------------------------------------------------------
  always @*
  begin
    next_pstate = pstate;
    case (pstate)
      P_OFF:
        if (touch_rise && !boot_block)
          next_pstate = P_BOOT;
      P_BOOT:
        if (run_wr && wr_data != 8'h00)
          next_pstate = P_RUN;
      P_RUN:
        if (touch_rise || vbat_low)
          next_pstate = P_SHDN;
        else if (run_wr && wr_data == 8'h00)
          next_pstate = P_SHDN;
      P_SHDN:
        if (!host_alive)
          next_pstate = P_OFF;
      default:
        next_pstate = P_OFF;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pstate <= P_OFF;
      host_pwr_o <= 1'b0;
      power_indicator_led_o <= 1'b0;
      led_cnt <= 32'h0000_0000;
      led_phase <= 1'b0;
    end
    else
    begin
      pstate <= next_pstate;
      host_pwr_o <= (next_pstate != P_OFF);
      if (led_cnt >= LED_HALF_CYC - 32'h1)
      begin
        led_cnt <= 32'h0000_0000;
        led_phase <= ~led_phase;
      end
      else
        led_cnt <= led_cnt + 32'h1;
      case (next_pstate)
        P_OFF: power_indicator_led_o <= 1'b0;
        P_RUN: power_indicator_led_o <= 1'b1;
        default: power_indicator_led_o <= led_phase;
      endcase
    end
  end

endmodule // hrc_core
`default_nettype wire

// [hrc_core_properties.sv]
// Port checks for the host run and commit block
`timescale 1ns/10ps
`default_nettype none
module hrc_core_props #(
  parameter [31:0] LED_HALF_CYC = 32'h4
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic host_alive_i,
  input wire logic host_pwr_o,
  input wire logic power_indicator_led_o,
  input wire logic nvm_req_o,
  input wire logic nvm_we_o,
  input wire logic [1:0] nvm_addr_o,
  input wire logic nvm_ack_i,
  input wire logic commit_busy_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_req_holds: assert property (nvm_req_o && !nvm_ack_i |=>
    nvm_req_o && $stable(nvm_addr_o) && $stable(nvm_we_o))
    else $error("nvm request changed early");
  chk_req_drops: assert property (nvm_ack_i |=> !nvm_req_o)
    else $error("nvm request not dropped");
  chk_next_byte: assert property (nvm_ack_i && nvm_addr_o != 2'h3
    |=> ##1 nvm_req_o && nvm_addr_o == $past(nvm_addr_o, 2) + 2'h1)
    else $error("nvm byte order wrong");
  chk_req_busy: assert property (nvm_req_o |-> commit_busy_o)
    else $error("nvm request while idle");
  chk_busy_ends: assert property (nvm_ack_i && nvm_addr_o == 2'h3
    |=> !commit_busy_o) else $error("busy after last byte");
  chk_store_first: assert property ($rose(nvm_req_o)
    && !$past(commit_busy_o, 2) && $past(rst_n_i) |->
    nvm_we_o && nvm_addr_o == 2'h0) else $error("store start wrong");
  chk_led_off: assert property (!host_pwr_o |->
    !power_indicator_led_o) else $error("led lit with host off");
  chk_pwr_hold: assert property (host_alive_i[*5] ##0 host_pwr_o
    |=> host_pwr_o) else $error("power cut while host alive");
endmodule // hrc_core_props
bind hrc_core hrc_core_props #(.LED_HALF_CYC(LED_HALF_CYC)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .host_alive_i(host_alive_i),
  .host_pwr_o(host_pwr_o), .power_indicator_led_o(power_indicator_led_o),
  .nvm_req_o(nvm_req_o), .nvm_we_o(nvm_we_o), .nvm_addr_o(nvm_addr_o),
  .nvm_ack_i(nvm_ack_i), .commit_busy_o(commit_busy_o)
);
`default_nettype wire

// [hrc_nvm_model.sv]
// Behavioural nonvolatile memory behind the commit block
`timescale 1ns/10ps
`default_nettype none
module hrc_nvm_model (
  input wire logic clk_i,
  input wire logic [15:0] lat_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic ack_o
);
  logic [7:0] mem [0:3] = '{8'h86, 8'h0B, 8'hB8, 8'h0B};
  logic [15:0] cnt = 16'h0;
  initial rdata_o = 8'h5A;
  initial ack_o = 1'b0;
  // Read data toggles outside a read ack cycle
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    cnt <= (req_i && !ack_o) ? cnt + 16'h1 : 16'h0;
    if (req_i && !ack_o && cnt >= lat_i)
    begin
      ack_o <= 1'b1;
      if (we_i)
        mem[addr_i] <= wdata_i;
      else
        rdata_o <= mem[addr_i];
    end
  end
endmodule // hrc_nvm_model
`default_nettype wire

// [host_run_state_and_config_commit_bench.sv]
// Self-checking bench for the host run and commit block
`timescale 1ns/10ps
`default_nettype none
`include "hrc_map.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  fails++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module host_run_state_and_config_commit_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic touch = 1'b0;
  logic alive = 1'b0;
  logic [15:0] vbat = 16'h0CE4;
  logic [15:0] vout = 16'h0C80;
  logic [15:0] lat = 16'h3;
  logic [7:0] q;
  logic [7:0] v;
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int nwr = 0;
  int hi;
  int seed = 48251;
  int cfg [4] = '{8'h86, 8'h0B, 8'hA0, 8'h0F};
  wire sda_o, sda_oe_o, power_indicator_led, led, req, we, ack, busy;
  wire [1:0] addr;
  wire [7:0] wdata, rdata;
  wire sda = (sda_oe_o ? sda_o : 1'b1) & sda_m;
  hrc_core #(.LED_HALF_CYC(32'h4)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .touch_i(touch), .host_alive_i(alive), .vbat_mv_i(vbat),
    .vout_mv_i(vout), .host_pwr_o(power_indicator_led), .power_indicator_led_o(led),
    .nvm_req_o(req), .nvm_we_o(we), .nvm_addr_o(addr),
    .nvm_wdata_o(wdata), .nvm_rdata_i(rdata), .nvm_ack_i(ack),
    .commit_busy_o(busy));
  hrc_nvm_model nvm (.clk_i(clk_i), .lat_i(lat), .req_i(req), .we_i(we),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .ack_o(ack));
  initial forever #5 clk_i = ~clk_i;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    nwr += (req && ack && we) ? 1 : 0;
    if (cycles == 60000)
    begin
      fails++;
      end_of_test;
    end
  end
  // ----------------------------------------------------------------
  // Bus and pin tasks
  // ----------------------------------------------------------------
  task automatic hb;
    repeat (8) @(negedge clk_i);
  endtask
  task automatic sbit(input logic b, output logic r);
    sda_m = b;
    hb;
    scl = 1'b1;
    hb;
    r = sda;
    scl = 1'b0;
    hb;
  endtask
  task automatic start;
    sda_m = 1'b1;
    hb;
    scl = 1'b1;
    hb;
    sda_m = 1'b0;
    hb;
    scl = 1'b0;
    hb;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    hb;
    scl = 1'b1;
    hb;
    sda_m = 1'b1;
    hb;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--)
      sbit(d[i], r[i]);
    sbit(1'b1, k);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    start;
    xb({`HRC_I2C_ADDR, 1'b0}, q);
    xb(ra, q);
    xb(d, q);
    stop;
  endtask
  task automatic rd(input logic [7:0] ra);
    start;
    xb({`HRC_I2C_ADDR, 1'b0}, q);
    xb(ra, q);
    start;
    xb({`HRC_I2C_ADDR, 1'b1}, q);
    xb(8'hFF, q);
    stop;
  endtask
  task automatic press;
    touch = 1'b1;
    repeat (12) @(negedge clk_i);
    touch = 1'b0;
    repeat (12) @(negedge clk_i);
  endtask
  task automatic reset_dut;
    rst_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_dut;
    press;
    `CHK("boot blocked", 1'b0, power_indicator_led)
    wr(`HRC_REG_CFG_BASE + 8'h2, 8'hA0);
    wr(`HRC_REG_CFG_BASE + 8'h3, 8'h0F);
    for (int c = 0; c < 3; c++)
    begin
      press;
      `CHK("boot", 1'b1, power_indicator_led)
      alive = 1'b1;
      rd(`HRC_REG_RUN);
      `CHK("flag boot", 8'h00, q)
      wr(`HRC_REG_RUN, 8'h01);
      rd(`HRC_REG_RUN);
      `CHK("flag run", 8'h01, q)
      if (c == 0)
        press;
      else if (c == 1)
        vbat = 16'h0B54;
      else
        wr(`HRC_REG_RUN, 8'h00);
      rd(`HRC_REG_RUN);
      `CHK("flag cleared", 8'h00, q)
      hi = 0;
      repeat (40) @(negedge clk_i) hi += (led === 1'b1) ? 1 : 0;
      `CHK("led pulses", 1'b1, hi > 0 && hi < 40)
      `CHK("power held", 1'b1, power_indicator_led)
      alive = 1'b0;
      vbat = 16'h0CE4;
      repeat (12) @(negedge clk_i);
      `CHK("power off", 1'b0, power_indicator_led)
    end
    press;
    alive = 1'b1;
    wr(`HRC_REG_RUN, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed));
      wr(`HRC_REG_COMMIT, (v == `HRC_COMMIT_CODE) ? 8'h47 : v);
    end
    rd(`HRC_REG_COMMIT);
    `CHK("commit read", `HRC_COMMIT_READ, q)
    `CHK("ignored stores", 0, nwr)
    lat = 16'd400;
    wr(`HRC_REG_COMMIT, `HRC_COMMIT_CODE);
    wr(`HRC_REG_COMMIT, `HRC_COMMIT_CODE);
    for (int i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge clk_i);
    `CHK("store count", 4, nwr)
    for (int i = 0; i < 4; i++)
      `CHK("stored byte", cfg[i][7:0], nvm.mem[i])
    rd(`HRC_REG_RUN);
    `CHK("run kept", 8'h01, q)
    `CHK("power kept", 1'b1, power_indicator_led)
    lat = 16'h3;
    wr(`HRC_REG_CFG_BASE + 8'h2, 8'h11);
    rd(`HRC_REG_CFG_BASE + 8'h2);
    `CHK("live setting", 8'h11, q)
    reset_dut;
    rd(`HRC_REG_CFG_BASE + 8'h2);
    `CHK("reloaded setting", 8'hA0, q)
    end_of_test;
  end
endmodule // host_run_state_and_config_commit_bench
`default_nettype wire
